// ### include/ssp_pkg.sv
//=============================================================================
// Functional notes
// - Slave transmit behaves like master transmit except during sleep.
// - First of two queued words moves to shifter at once and shifts.
// - Second word waits in holding; empty flag stays clear meanwhile.
// - After first word ends, second loads into shifter, then flag sets.
// - Raised transmit flag with its enable wakes device; interrupt follows.
// - Slave mode needs sync bit and port enable set, clock source clear.
// - Nine-bit transmit sends ninth bit field after the eight data bits.
// - With transmit enable set, writing holding register starts transmit.
// - Single-receive enable is ignored; continuous enable alone controls.
// - Continuous receive keeps working in sleep or idle.
// - Complete word moves from receive shifter into receive buffer.
// - Receive flag with its enable wakes device from sleep or idle.
// - Receive flag sets on completion; interrupt only if enabled.
// - Nine-bit receive by its enable; status read before data read.
// - Clearing continuous-receive enable clears pending receive errors.
// - Shift clock comes in on the clock pin from the external master.
// - Transmit empty flag is read-only, cleared only by holding write.
// - Read-only shifter-empty bit set while transmit shifter holds nothing.
//=============================================================================
package ssp_pkg;
  // Register offsets
  localparam logic [3:0] ADDR_FLAGS    = 4'h0;
  localparam logic [3:0] ADDR_ENABLES  = 4'h1;
  localparam logic [3:0] ADDR_PRIORITY = 4'h2;
  localparam logic [3:0] ADDR_RXSTAT   = 4'h3;
  localparam logic [3:0] ADDR_TXHOLD   = 4'h4;
  localparam logic [3:0] ADDR_TXSTAT   = 4'h5;
  localparam logic [3:0] ADDR_RATECTL  = 4'h6;
  localparam logic [3:0] ADDR_DIVHI    = 4'h7;
  localparam logic [3:0] ADDR_DIVLO    = 4'h8;
  localparam logic [3:0] ADDR_RXBUF    = 4'h9;
  // Flag and enable bit positions
  localparam int BIT_RXFLAG = 5;
  localparam int BIT_TXFLAG = 4;
  // Receive status and control bits
  localparam int BIT_PORT_EN = 7;
  localparam int BIT_RX9_EN  = 6;
  localparam int BIT_SINGLE_RECEIVE_ENABLE    = 5;
  localparam int BIT_CONTINUOUS_RECEIVE_ENABLE    = 4;
  localparam int BIT_ADDEN   = 3;
  localparam int BIT_FRAMERR = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_RX_NINTH_BIT    = 0;
  // Transmit status and control bits
  localparam int BIT_CLKSRC  = 7;
  localparam int BIT_TX9_EN  = 6;
  localparam int BIT_TX_EN   = 5;
  localparam int BIT_SYNC    = 4;
  localparam int BIT_SHIFTER_EMPTY_STATUS    = 1;
  localparam int BIT_TX_NINTH_BIT    = 0;
  // Reset values and rate-control write mask
  localparam logic [7:0] RESET_ZERO   = 8'h00;
  localparam logic [7:0] RESET_TXSTAT = 8'h02;
  localparam logic [7:0] RATECTL_MASK = 8'hFB;
  // Word lengths in bits
  localparam logic [3:0] LEN_EIGHT = 4'h8;
  localparam logic [3:0] LEN_NINE  = 4'h9;
endpackage

// ### hw/ssp_slave.sv
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module ssp_slave
  import ssp_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RESET,
  // Register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Serial pins
  input  wire logic       SHIFT_CLOCK_PIN,
  input  wire logic       DATA_IN,
  output logic            DATA_OUT,
  output logic            DATA_OE,
  // Low-power status and wake
  input  wire logic       LOW_POWER,
  output logic            TX_IRQ,
  output logic            RX_IRQ,
  output logic            WAKE
);

  //===========================================================================
  // Registers
  logic [7:0] enables;
  logic [7:0] priority_reg;
  logic [7:0] rate_control;
  logic [7:0] div_hi;
  logic [7:0] div_lo;
  logic       port_enable;
  logic       rx_nine_bit_enable;
  logic       single_receive_enable;
  logic       continuous_receive_enable;
  logic       addr_detect;
  logic       clock_source_select;
  logic       tx_nine_bit_enable;
  logic       transmit_enable;
  logic       sync_mode;
  logic       tx_ninth_bit;
  logic [7:0] transmit_holding;
  logic       hold_full;
  logic       tx_buffer_empty_flag;
  logic [8:0] transmit_shifter;
  logic [3:0] tx_count;
  logic       shifter_busy;
  logic [8:0] receive_shifter;
  logic [3:0] rx_count;
  logic [7:0] receive_buffer;
  logic       rx_ninth_bit;
  logic       rx_complete_flag;
  logic       overrun;
  logic       ck_meta;
  logic       ck_sync;
  logic       ck_last;
  logic       din_meta;
  logic       din_sync;

  //===========================================================================
  // Decodes
  logic       slave_mode;
  logic       ck_rise;
  logic       ck_fall;
  logic       wr_hold;
  logic       rd_buf;
  logic       load_shifter;
  logic       tx_done;
  logic       rx_done;
  logic [3:0] tx_len;
  logic [3:0] rx_len;

  // Slave mode select
  assign slave_mode = sync_mode & port_enable & ~clock_source_select;
  // Pin clock edges, read only after the second synchroniser stage
  assign ck_rise = ck_sync & ~ck_last;
  assign ck_fall = ~ck_sync & ck_last;
  assign wr_hold = WR & (ADDR == ADDR_TXHOLD);
  assign rd_buf  = RD & (ADDR == ADDR_RXBUF);
  assign tx_len  = tx_nine_bit_enable ? LEN_NINE : LEN_EIGHT;
  assign rx_len  = rx_nine_bit_enable ? LEN_NINE : LEN_EIGHT;
  // Last bit of a word leaves on a rising edge
  assign tx_done = shifter_busy & ck_rise & (tx_count == tx_len - 4'h1);
  // Shifter takes held word whenever it is free in slave mode with transmit enabled; sleep changes nothing
  assign load_shifter = hold_full & ~shifter_busy & transmit_enable
                        & slave_mode;
  // Receive samples on falling edges, continuous enable only
  assign rx_done = slave_mode & continuous_receive_enable & ck_fall
                   & (rx_count == rx_len - 4'h1);

  //===========================================================================
  // Input synchronisers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ck_meta  <= 1'b0;
      ck_sync  <= 1'b0;
      ck_last  <= 1'b0;
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      ck_meta  <= SHIFT_CLOCK_PIN;
      ck_sync  <= ck_meta;
      ck_last  <= ck_sync;
      din_meta <= DATA_IN;
      din_sync <= din_meta;
    end
  end

  //===========================================================================
  // Control registers written by software
  always_ff @(posedge CLK) begin
    if (RESET) begin
      enables                   <= RESET_ZERO;
      priority_reg              <= RESET_ZERO;
      rate_control              <= RESET_ZERO;
      div_hi                    <= RESET_ZERO;
      div_lo                    <= RESET_ZERO;
      port_enable               <= 1'b0;
      rx_nine_bit_enable        <= 1'b0;
      single_receive_enable     <= 1'b0;
      continuous_receive_enable <= 1'b0;
      addr_detect               <= 1'b0;
      clock_source_select       <= 1'b0;
      tx_nine_bit_enable        <= 1'b0;
      transmit_enable           <= 1'b0;
      sync_mode                 <= 1'b0;
      tx_ninth_bit              <= 1'b0;
    end else if (WR) begin
      unique case (ADDR)
        ADDR_ENABLES:  enables      <= WDATA;
        ADDR_PRIORITY: priority_reg <= WDATA;
        ADDR_RATECTL:  rate_control <= WDATA & RATECTL_MASK;
        ADDR_DIVHI:    div_hi       <= WDATA;
        ADDR_DIVLO:    div_lo       <= WDATA;
        ADDR_RXSTAT: begin
          port_enable               <= WDATA[BIT_PORT_EN];
          rx_nine_bit_enable        <= WDATA[BIT_RX9_EN];
          single_receive_enable     <= WDATA[BIT_SINGLE_RECEIVE_ENABLE];
          continuous_receive_enable <= WDATA[BIT_CONTINUOUS_RECEIVE_ENABLE];
          addr_detect               <= WDATA[BIT_ADDEN];
        end
        ADDR_TXSTAT: begin
          clock_source_select <= WDATA[BIT_CLKSRC];
          tx_nine_bit_enable  <= WDATA[BIT_TX9_EN];
          transmit_enable     <= WDATA[BIT_TX_EN];
          sync_mode           <= WDATA[BIT_SYNC];
          tx_ninth_bit        <= WDATA[BIT_TX_NINTH_BIT];
        end
        default: ;
      endcase
    end
  end

  //===========================================================================
  // Transmit holding register and empty flag
  always_ff @(posedge CLK) begin
    if (RESET) begin
      transmit_holding     <= RESET_ZERO;
      hold_full            <= 1'b0;
      tx_buffer_empty_flag <= 1'b0;
    end else if (wr_hold) begin
      transmit_holding     <= WDATA;
      hold_full            <= 1'b1;
      tx_buffer_empty_flag <= 1'b0;     // Only a holding write clears
    end else if (load_shifter) begin
      hold_full            <= 1'b0;
      tx_buffer_empty_flag <= 1'b1;     // Set after the hand-off
    end
  end

  //===========================================================================
  // Transmit shifter, LSB first, ninth bit last
  always_ff @(posedge CLK) begin
    if (RESET) begin
      transmit_shifter <= 9'h000;
      tx_count         <= 4'h0;
      shifter_busy     <= 1'b0;
    end else if (!slave_mode || !transmit_enable) begin
      shifter_busy <= 1'b0;
      tx_count     <= 4'h0;
    end else if (load_shifter) begin
      transmit_shifter <= {tx_ninth_bit, transmit_holding};
      tx_count         <= 4'h0;
      shifter_busy     <= 1'b1;
    end else if (tx_done) begin
      shifter_busy <= 1'b0;             // Next word may now load
    end else if (shifter_busy && ck_rise) begin
      transmit_shifter <= {1'b0, transmit_shifter[8:1]};
      tx_count         <= tx_count + 4'h1;
    end
  end

  // Data pin drive: bit 0 of shifter stands until next rising edge
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DATA_OUT <= 1'b0;
      DATA_OE  <= 1'b0;
    end else begin
      DATA_OUT <= transmit_shifter[0];
      DATA_OE  <= slave_mode & transmit_enable;
    end
  end

  //===========================================================================
  // Receive shifter
  always_ff @(posedge CLK) begin
    if (RESET) begin
      receive_shifter <= 9'h000;
      rx_count        <= 4'h0;
    end else if (!slave_mode || !continuous_receive_enable) begin
      rx_count <= 4'h0;
    end else if (ck_fall) begin
      receive_shifter <= {din_sync, receive_shifter[8:1]};
      rx_count <= rx_done ? 4'h0 : rx_count + 4'h1;
    end
  end

  // Receive buffer, flag and overrun error
  always_ff @(posedge CLK) begin
    if (RESET) begin
      receive_buffer   <= RESET_ZERO;
      rx_ninth_bit     <= 1'b0;
      rx_complete_flag <= 1'b0;
      overrun          <= 1'b0;
    end else begin
      // A word that arrives over an unread buffer is dropped
      if (rx_done && !overrun && (!rx_complete_flag || rd_buf)) begin
        // Nine-bit word: eight data bits low, last bit is the ninth
        if (rx_nine_bit_enable) begin
          receive_buffer <= receive_shifter[8:1];
          rx_ninth_bit   <= din_sync;
        end else begin
          receive_buffer <= {din_sync, receive_shifter[8:2]};
          rx_ninth_bit   <= 1'b0;
        end
        rx_complete_flag <= 1'b1;
      end else if (rd_buf) begin
        rx_complete_flag <= 1'b0;
      end
      // Word lost while buffer still unread
      if (rx_done && rx_complete_flag && !rd_buf) begin
        overrun <= 1'b1;
      end else if (!continuous_receive_enable) begin
        overrun <= 1'b0;
      end
    end
  end

  //===========================================================================
  // Interrupt requests and wake
  always_ff @(posedge CLK) begin
    if (RESET) begin
      TX_IRQ <= 1'b0;
      RX_IRQ <= 1'b0;
      WAKE   <= 1'b0;
    end else begin
      TX_IRQ <= tx_buffer_empty_flag & enables[BIT_TXFLAG];
      RX_IRQ <= rx_complete_flag & enables[BIT_RXFLAG];
      WAKE   <= LOW_POWER & ((tx_buffer_empty_flag & enables[BIT_TXFLAG])
                | (rx_complete_flag & enables[BIT_RXFLAG]));
    end
  end

  //===========================================================================
  // Read data, one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA <= RESET_ZERO;
    end else if (RD) begin
      unique case (ADDR)
        ADDR_FLAGS:    RDATA <= {2'b00, rx_complete_flag,
                                 tx_buffer_empty_flag, 4'h0};
        ADDR_ENABLES:  RDATA <= enables;
        ADDR_PRIORITY: RDATA <= priority_reg;
        ADDR_RXSTAT:   RDATA <= {port_enable, rx_nine_bit_enable,
                                 single_receive_enable,
                                 continuous_receive_enable, addr_detect,
                                 1'b0, overrun, rx_ninth_bit};
        ADDR_TXSTAT:   RDATA <= {clock_source_select, tx_nine_bit_enable,
                                 transmit_enable, sync_mode, 2'b00,
                                 ~shifter_busy, tx_ninth_bit};
        ADDR_RATECTL:  RDATA <= rate_control;
        ADDR_DIVHI:    RDATA <= div_hi;
        ADDR_DIVLO:    RDATA <= div_lo;
        ADDR_RXBUF:    RDATA <= receive_buffer;
        default:       RDATA <= RESET_ZERO;
      endcase
    end else begin
      RDATA <= RESET_ZERO;
    end
  end

endmodule

// ### tb/ssp_slave_assertions.sv
`timescale 1ns/100ps
//=========================================
// Port checker
module ssp_slave_assertions (
  // Clock, reset and strobes
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Pins and events
  input wire logic       SHIFT_CLOCK_PIN,
  input wire logic       DATA_OUT,
  input wire logic       DATA_OE,
  input wire logic       LOW_POWER,
  input wire logic       TX_IRQ,
  input wire logic       RX_IRQ,
  input wire logic       WAKE
);
  logic [1:0] pin_q;
  logic [3:0] since;
  logic [2:0] wr_q;
  logic [2:0] acc_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Recent strobes and pin samples
  always_ff @(posedge CLK) begin
    pin_q <= {pin_q[0], SHIFT_CLOCK_PIN};
    wr_q  <= {wr_q[1:0], WR};
    acc_q <= {acc_q[1:0], WR | RD};
  end
  // Cycles since a pin rise or a write
  always_ff @(posedge CLK) begin
    if (RESET || WR || pin_q == 2'h1)
      since <= 4'h0;
    else if (since != 4'hF)
      since <= since + 4'h1;
  end
  chk_rdata_idle: assert property (
    !$past(RD) |-> RDATA == 8'h00) else $error("stray read data");
  chk_wake_cause: assert property (
    WAKE |-> $past(LOW_POWER) && (TX_IRQ || RX_IRQ))
    else $error("wake without cause");
  chk_wake_tx: assert property (
    $rose(TX_IRQ) && $past(LOW_POWER) |-> WAKE)
    else $error("no wake on transmit");
  chk_wake_rx: assert property (
    $rose(RX_IRQ) && $past(LOW_POWER) |-> WAKE)
    else $error("no wake on receive");
  chk_txirq_hold: assert property (
    $fell(TX_IRQ) |-> wr_q != 3'h0) else $error("transmit flag lost");
  chk_rxirq_hold: assert property (
    $fell(RX_IRQ) |-> acc_q != 3'h0) else $error("receive flag lost");
  chk_oe_cause: assert property (
    $changed(DATA_OE) |-> wr_q != 3'h0) else $error("enable moved");
  chk_out_timing: assert property (
    $changed(DATA_OUT) |-> since <= 4'h6) else $error("late bit");
  cover property ($rose(TX_IRQ));
  cover property ($rose(RX_IRQ));
  cover property ($rose(WAKE));
endmodule

bind ssp_slave ssp_slave_assertions chk_u (.CLK, .RESET, .WR, .RD,
  .RDATA, .SHIFT_CLOCK_PIN, .DATA_OUT, .DATA_OE, .LOW_POWER,
  .TX_IRQ, .RX_IRQ, .WAKE);

// ### tb/ssp_ext_master.sv
`timescale 1ns/100ps
//=========================================
// External shift-clock master
module ssp_ext_master (
  // Frame request
  input  wire logic       go,
  input  wire logic [8:0] word,
  input  wire logic [3:0] nbits,
  input  wire logic       slow,
  // Link pins
  input  wire logic       dout,
  output logic            sck,
  output logic            sdo,
  // Result
  output logic [8:0]      cap,
  output logic            busy
);
  initial begin
    sck = 1'b0;
    sdo = 1'b1;
    cap = 9'h000;
    busy = 1'b0;
  end
  // One frame per request; clock stands low between frames
  always @(posedge go) begin
    busy = 1'b1;
    cap = 9'h000;
    #25;
    for (int i = 0; i < nbits; i++) begin
      sdo = word[i];        // LSB first, ninth bit last
      #100 cap[i] = dout;   // Taken before the shifting edge
      sck = 1'b1;           // Clock comes from outside
      #400 sck = 1'b0;
      #(slow ? 1000 : 300); // Data held past the sampling edge
    end
    sdo = ~sdo;             // Released line shows no stale bit
    busy = 1'b0;
  end
endmodule

// ### tb/ssp_slave_tb_top.sv
`timescale 1ns/100ps
//=========================================
// Bench top
module ssp_slave_tb_top;
  import ssp_pkg::*;
  logic       CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0;
  logic       LOW_POWER = 1'b0, go = 1'b0, slow = 1'b0;
  logic [3:0] ADDR = 4'h0, nbits = 4'h8;
  logic [7:0] WDATA = 8'h00, RDATA;
  logic [8:0] word = 9'h000, cap;
  logic       DATA_OUT, DATA_OE, TX_IRQ, RX_IRQ, WAKE, sck, sdo, busy;
  int         error_cnt, check_count;
  // Design and far-side master
  ssp_slave dut_u (.CLK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .SHIFT_CLOCK_PIN(sck), .DATA_IN(sdo), .DATA_OUT, .DATA_OE,
    .LOW_POWER, .TX_IRQ, .RX_IRQ, .WAKE);
  ssp_ext_master ext_u (.go, .word, .nbits, .slow, .dout(DATA_OUT),
    .sck, .sdo, .cap, .busy);
  // System clock
  always #50 CLK = ~CLK;
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // Read one register and compare the masked bits
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [7:0] m, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(nm, {1'b0, RDATA & m}, {1'b0, e});
  endtask
  // One frame from the far-side master, bounded wait
  task automatic frame(input logic [8:0] w, input logic [3:0] n);
    @(posedge CLK);
    word <= w;
    nbits <= n;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    for (int k = 0; k < 300 && busy; k++)
      @(posedge CLK);
    if (busy !== 1'b0) begin
      error_cnt++;
      print_verdict();
    end
    repeat (8) @(posedge CLK);
  endtask
  task automatic t_reset();
    for (int a = 0; a < 10; a++)
      rchk("reset", a[3:0], 8'hFF, a == 5 ? RESET_TXSTAT : RESET_ZERO);
    wr(4'hF, 8'hFF);
    rchk("unmapped", 4'hF, 8'hFF, 8'h00);
    wr(ADDR_FLAGS, 8'h10);
    rchk("flag ro", ADDR_FLAGS, 8'h10, 8'h00);
  endtask
  task automatic t_tx();
    wr(ADDR_RXSTAT, 8'h80);           // Receive enables clear
    wr(ADDR_TXSTAT, 8'hB0);
    wr(ADDR_ENABLES, 8'h10);
    chk("oe master", DATA_OE, 9'h000);
    wr(ADDR_TXSTAT, 8'h30);
    LOW_POWER <= 1'b1;
    wr(ADDR_TXHOLD, 8'hA5);
    wr(ADDR_TXHOLD, 8'h3C);
    chk("oe slave", DATA_OE, 9'h001);
    rchk("held flag", ADDR_FLAGS, 8'h10, 8'h00);
    rchk("busy shifter", ADDR_TXSTAT, 8'h02, 8'h00);
    frame(9'h000, 4'h8);
    chk("word one", cap, 9'h0A5);
    rchk("flag set", ADDR_FLAGS, 8'h10, 8'h10);
    chk("wake tx", WAKE, 9'h001);
    frame(9'h000, 4'h8);
    chk("word two", cap, 9'h03C);
    rchk("idle shifter", ADDR_TXSTAT, 8'h02, 8'h02);
    wr(ADDR_TXSTAT, 8'h71);
    wr(ADDR_TXHOLD, 8'h5A);
    rchk("load now", ADDR_TXSTAT, 8'h02, 8'h00);
    frame(9'h000, 4'h9);
    chk("nine bits", cap, 9'h15A);
  endtask
  task automatic t_rx();
    wr(ADDR_TXSTAT, 8'h10);
    wr(ADDR_ENABLES, 8'h20);
    wr(ADDR_RXSTAT, 8'hA0);
    frame(9'h0C3, 4'h8);
    rchk("single off", ADDR_FLAGS, 8'h20, 8'h00);
    wr(ADDR_RXSTAT, 8'h90);
    slow <= 1'b1;
    frame(9'h0C3, 4'h8);
    slow <= 1'b0;
    chk("rx irq", RX_IRQ, 9'h001);
    chk("wake rx", WAKE, 9'h001);
    rchk("rx status", ADDR_RXSTAT, 8'h03, 8'h00);
    rchk("rx data", ADDR_RXBUF, 8'hFF, 8'hC3);
    rchk("flag clr", ADDR_FLAGS, 8'h20, 8'h00);
    wr(ADDR_ENABLES, 8'h00);
    frame(9'h011, 4'h8);
    chk("masked", RX_IRQ, 9'h000);
    frame(9'h022, 4'h8);
    rchk("overrun", ADDR_RXSTAT, 8'h02, 8'h02);
    wr(ADDR_RXSTAT, 8'h80);
    rchk("err clr", ADDR_RXSTAT, 8'h02, 8'h00);
    rchk("kept", ADDR_RXBUF, 8'hFF, 8'h11);
    wr(ADDR_RXSTAT, 8'hD0);
    frame(9'h196, 4'h9);
    rchk("ninth", ADDR_RXSTAT, 8'h01, 8'h01);
    rchk("low byte", ADDR_RXBUF, 8'hFF, 8'h96);
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    print_verdict();
  end
endmodule
